// file: src/prhg_top.sv
// Output gate and health monitor for a physical random generator
// Overview of operation
// - Total-failure check runs on raw bits from the moment of start-up.
// - After total failure is seen, no random word is ever delivered.
// - Words holding bits gathered after a failure are discarded.
// - Online test checks raw bits at start-up and during operation.
// - No output until start-up test passes, nor after a defect.
// - Online test runs continuously on every raw bit.
// - Online test flags weaknesses within one test window.
// - Words are delivered as 8 or 16 bits, chosen by a width input.
// - Raw bits are passed unaltered; quality rests on the source.
// - Entropy per bit above 0.997 is a property of the source.
`include "prhg_cfg.svh"
module prhg_top
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic raw_bit,
   input wire logic raw_vld,
   input wire logic wide_sel,
   input wire logic word_take,
   output logic [15:0] rnd_word,
   output logic rnd_valid,
   output prhg_pkg::prhg_state_type gate_state,
   output logic fail_flag,
   output logic defect_flag
);
   import prhg_pkg::*;
   prhg_state_type state_q;
   prhg_state_type state_d;
   logic bit_s1_q;
   logic bit_s2_q;
   logic vld_s1_q;
   logic vld_s2_q;
   logic vld_s3_q;
   logic bit_vld;
   logic dead;
   logic win_done;
   logic win_bad;
   logic [3:0] good_wins_q;
   logic [15:0] shift_q;
   logic [4:0] fill_q;
   logic [4:0] fill_need;
   logic word_full;
   logic fail_q;
   logic defect_q;
   logic taken;
   logic gate_open;
   // Two-flop capture of the pin inputs; raw_vld edge gives one pulse
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bit_s1_q <= 1'b0;
         bit_s2_q <= 1'b0;
         vld_s1_q <= 1'b0;
         vld_s2_q <= 1'b0;
         vld_s3_q <= 1'b0;
      end
      else
      begin
         bit_s1_q <= raw_bit;
         bit_s2_q <= bit_s1_q;
         vld_s1_q <= raw_vld;
         vld_s2_q <= vld_s1_q;
         vld_s3_q <= vld_s2_q;
      end
   end
   assign bit_vld = vld_s2_q && !vld_s3_q;
   // Health tests see every raw bit, never only on request
   prhg_online_test u_test
   (
      .mclk(mclk),
      .arst_n(arst_n),
      .bit_vld(bit_vld),
      .bit_val(bit_s2_q),
      .dead(dead),
      .win_done(win_done),
      .win_bad(win_bad)
   );
   // Sticky flags; nothing clears them short of reset
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fail_q <= 1'b0;
         defect_q <= 1'b0;
      end
      else
      begin
         if (dead)
            fail_q <= 1'b1;
         if (win_bad)
            defect_q <= 1'b1;
      end
   end
   // Count passing windows during start-up
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         good_wins_q <= 4'h0;
      else if (state_q == PRHG_ST_STARTUP && win_done && !win_bad)
         good_wins_q <= good_wins_q + 4'h1;
   end
   // Gate state; halt is final until reset
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         PRHG_ST_STARTUP:
         begin
            if (dead || win_bad || fail_q || defect_q)
               state_d = PRHG_ST_HALT;
            else if (good_wins_q == `PRHG_STARTUP_WINS)
               state_d = PRHG_ST_RUN;
         end
         PRHG_ST_RUN:
         begin
            if (dead || win_bad)
               state_d = PRHG_ST_HALT;
         end
         PRHG_ST_HALT:
            state_d = PRHG_ST_HALT;
      endcase
   end
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         state_q <= PRHG_ST_STARTUP;
      else
         state_q <= state_d;
   end
   // Word assembly; width chosen per word by the select input
   assign fill_need = wide_sel ? 5'h10 : 5'h08;
   assign word_full = (fill_q >= fill_need);
   assign gate_open = (state_q == PRHG_ST_RUN) && !dead && !win_bad;
   assign taken = rnd_valid && word_take;
   // Dead run also purges partial words: their late bits are suspect
   // Start-up bits feed only the tests, so no stale word greets run
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         shift_q <= 16'h0000;
         fill_q <= 5'h00;
      end
      else if (dead || state_q != PRHG_ST_RUN)
      begin
         shift_q <= 16'h0000;
         fill_q <= 5'h00;
      end
      else if (taken)
         fill_q <= 5'h00;
      else if (bit_vld && !word_full)
      begin
         shift_q <= {shift_q[14:0], bit_s2_q};
         fill_q <= fill_q + 5'h01;
      end
   end
   // Registered output; valid drops at once when the gate closes
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rnd_word <= 16'h0000;
         rnd_valid <= 1'b0;
         gate_state <= PRHG_ST_STARTUP;
         fail_flag <= 1'b0;
         defect_flag <= 1'b0;
      end
      else
      begin
         rnd_valid <= gate_open && word_full && !taken;
         rnd_word <= (gate_open && word_full)
            ? (wide_sel ? shift_q : {8'h00, shift_q[7:0]})
            : 16'h0000;
         gate_state <= state_d;
         fail_flag <= fail_q || dead;
         defect_flag <= defect_q || win_bad;
      end
   end
endmodule

// file: common/prhg_cfg.svh
// Timing and threshold constants for the random health gate
`ifndef PRHG_CFG_SVH
`define PRHG_CFG_SVH
`define PRHG_DEAD_RUN 8'h20
`define PRHG_WIN_BITS 12'h100
`define PRHG_BAL_LO 12'h060
`define PRHG_BAL_HI 12'h0A0
`define PRHG_STARTUP_WINS 4'h4
`define PRHG_DEAD_RUN_RST 8'h00
`endif

// file: common/prhg_pkg.sv
// Types shared by the random health gate
package prhg_pkg;
   typedef enum logic [1:0]
   {
      PRHG_ST_STARTUP = 2'b00,
      PRHG_ST_RUN = 2'b01,
      PRHG_ST_HALT = 2'b11
   } prhg_state_type;
endpackage

// file: src/prhg_online_test.sv
// Windowed balance and run-length test on the raw bit stream
`include "prhg_cfg.svh"
module prhg_online_test
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic bit_vld,
   input wire logic bit_val,
   output logic dead,
   output logic win_done,
   output logic win_bad
);
   import prhg_pkg::*;
   logic [7:0] run_q;
   logic [7:0] run_d;
   logic [11:0] cnt_q;
   logic [11:0] ones_q;
   logic prev_q;
   logic last_bit;
   logic [11:0] ones_fin;
   // Run length counts the current bit itself, so 32 equal bits read 32
   assign run_d = (bit_val == prev_q) ? run_q + 8'h01 : 8'h01;
   assign last_bit = bit_vld && (cnt_q == `PRHG_WIN_BITS - 12'h001);
   assign ones_fin = ones_q + {11'h000, bit_val};
   assign dead = (run_q >= `PRHG_DEAD_RUN);
   // Run counter saturates so a stuck source stays flagged
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         run_q <= `PRHG_DEAD_RUN_RST;
         prev_q <= 1'b0;
      end
      else if (bit_vld)
      begin
         prev_q <= bit_val;
         if (!dead)
            run_q <= run_d;
      end
   end
   // Window accumulation, verdict pulsed on the last bit
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q <= 12'h000;
         ones_q <= 12'h000;
         win_done <= 1'b0;
         win_bad <= 1'b0;
      end
      else
      begin
         win_done <= last_bit;
         win_bad <= last_bit &&
            ((ones_fin < `PRHG_BAL_LO) || (ones_fin > `PRHG_BAL_HI));
         if (last_bit)
         begin
            cnt_q <= 12'h000;
            ones_q <= 12'h000;
         end
         else if (bit_vld)
         begin
            cnt_q <= cnt_q + 12'h001;
            ones_q <= ones_fin;
         end
      end
   end
endmodule

// file: verification/prhg_top_assertions.sv
// Port-level timing checks for the random health gate
module prhg_top_assertions
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic wide_sel,
   input wire logic word_take,
   input wire logic [15:0] rnd_word,
   input wire logic rnd_valid,
   input wire prhg_pkg::prhg_state_type gate_state,
   input wire logic fail_flag,
   input wire logic defect_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   import prhg_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Word left unclaimed while the gate stays healthy
   sequence s_held;
      rnd_valid && !word_take
      ##1 gate_state == PRHG_ST_RUN && !fail_flag && !defect_flag;
   endsequence
   a_halt_final: assert property (gate_state == PRHG_ST_HALT
      |=> gate_state == PRHG_ST_HALT) else $error("halt left");
   a_no_word_idle: assert property (gate_state != PRHG_ST_RUN
      |-> !rnd_valid) else $error("word outside run");
   a_fail_halts: assert property ($rose(fail_flag)
      |-> ##[0:1] gate_state == PRHG_ST_HALT) else $error("no halt");
   a_fail_sticky: assert property (fail_flag |=> fail_flag)
      else $error("fail flag cleared");
   a_defect_sticky: assert property (defect_flag |=> defect_flag)
      else $error("defect flag cleared");
   a_take_clears: assert property (rnd_valid && word_take
      |=> !rnd_valid) else $error("valid after take");
   a_narrow_word: assert property (rnd_valid && !wide_sel
      |-> rnd_word[15:8] == 8'h00) else $error("narrow word upper");
   a_valid_holds: assert property (s_held |-> rnd_valid)
      else $error("word vanished");
endmodule

bind prhg_top prhg_top_assertions u_chk (.mclk(mclk), .arst_n(arst_n),
   .wide_sel(wide_sel), .word_take(word_take), .rnd_word(rnd_word),
   .rnd_valid(rnd_valid), .gate_state(gate_state),
   .fail_flag(fail_flag), .defect_flag(defect_flag));

// file: verification/prhg_consumer.sv
// Consumer model that takes each offered random word
module prhg_consumer
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic rnd_valid,
   input wire logic go,
   output logic word_take
);
   timeunit 1ns;
   timeprecision 1ns;
   // One pulse per word; go low stalls to hold a word waiting
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         word_take <= 1'b0;
      else
         word_take <= rnd_valid && go && !word_take;
   end
endmodule

// file: verification/physical_rng_health_gate_test.sv
// Self-checking bench for the random health gate
module physical_rng_health_gate_test;
   timeunit 1ns;
   timeprecision 1ns;
   import prhg_pkg::*;
   logic mclk = 0, arst_n = 0, raw_bit = 0, raw_vld = 0, wide_sel = 0;
   logic go = 0, word_take, rnd_valid, fail_flag, defect_flag;
   logic [15:0] rnd_word;
   prhg_state_type gate_state;
   int error_cnt = 0, checked = 0, exp, i;
   initial forever #20 mclk = ~mclk;
   prhg_top u_prhg_top (.mclk(mclk), .arst_n(arst_n), .raw_bit(raw_bit),
      .raw_vld(raw_vld), .wide_sel(wide_sel), .word_take(word_take),
      .rnd_word(rnd_word), .rnd_valid(rnd_valid), .gate_state(gate_state),
      .fail_flag(fail_flag), .defect_flag(defect_flag));
   prhg_consumer u_prhg_consumer (.mclk(mclk), .arst_n(arst_n),
      .rnd_valid(rnd_valid), .go(go), .word_take(word_take));
   task give_verdict;
      $display("errors %0d checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] want);
      checked++;
      if (got !== want)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, want);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   // Strobe high 2, low 4 so each bit settles before the next
   task send(input logic b);
      raw_bit = b;
      raw_vld = 1;
      tick(2);
      raw_vld = 0;
      tick(4);
   endtask
   task rst;
      arst_n = 0;
      tick(5);
      arst_n = 1;
      tick(1);
   endtask
   // Bounded wait on the word-valid level
   task wait_v(input logic v);
      for (int k = 0; k < 50 && rnd_valid !== v; k++)
         tick(1);
      if (rnd_valid !== v)
      begin
         error_cnt++;
         give_verdict;
      end
   endtask
   initial
   begin
      void'($urandom(21));
      rst;
      repeat (1100)
         if (gate_state !== PRHG_ST_RUN)
            send(1'($urandom_range(1)));
      chk(gate_state, PRHG_ST_RUN);
      // Model shifts bits in first-bit-highest, stalled consumer
      repeat (6)
      begin
         go = 0;
         wide_sel = 1'($urandom_range(1));
         exp = 0;
         repeat (wide_sel ? 16 : 8)
         begin
            i = $urandom_range(1);
            exp = (exp << 1) | i;
            send(1'(i));
         end
         wait_v(1);
         chk(rnd_word, 16'(exp));
         go = 1;
         wait_v(0);
      end
      // Source dies mid-word in run, then again during start-up after reset
      wide_sel = 0;
      repeat (5) send(1'($urandom_range(1)));
      repeat (32) send(0);
      tick(3);
      chk(rnd_valid, 0);
      chk(gate_state, PRHG_ST_HALT);
      rst;
      repeat (32) send(0);
      chk(fail_flag, 1);
      repeat (40) send(1'($urandom_range(1)));
      chk(rnd_valid, 0);
      rst;
      // Sparse ones: no dead run but far outside the balance band
      for (i = 0; i < 256; i++)
         send(i % 16 == 0);
      tick(3);
      chk(defect_flag, 1);
      chk(fail_flag, 0);
      chk(gate_state, PRHG_ST_HALT);
      give_verdict;
   end
endmodule
